// *** src/ssr_pkg.sv ***
// Purpose : shared constants for the supply status, mask and enable register bank
// Assumes : eight-bit registers behind a byte-wide register port
// Notes   : offsets are the register port addresses
package ssr_pkg;
    // ----------------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------------
    localparam logic [7:0] REVISION_ID_OFS     = 8'h00;
    localparam logic [7:0] SUPPLY_HEALTH_OFS   = 8'h01;
    localparam logic [7:0] FAULT_MASK_OFS      = 8'h02;
    localparam logic [7:0] SUPPLY_ENABLE_OFS   = 8'h03;
    localparam logic [6:0] SERIAL_DEVICE_ADDR  = 7'h48;
    // ----------------------------------------------------------------------
    // reset and fixed values
    // ----------------------------------------------------------------------
    localparam logic [7:0] FAULT_MASK_RST      = 8'hC0;
    localparam logic [7:0] SUPPLY_ENABLE_RST   = 8'hFF;
    localparam logic [7:0] UNMAPPED_READ_VAL   = 8'hFF;
    localparam logic [7:0] REVISION_ID_DEF     = 8'h5A;
    // ----------------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------------
    localparam int POWER_FAIL_BIT   = 7;
    localparam int LOW_BATTERY_BIT  = 6;
    localparam int RAIL_ONE_BIT     = 5;
    localparam int RAIL_TWO_BIT     = 4;
    localparam int RAIL_THREE_BIT   = 3;
    localparam int REG_TWO_BIT      = 2;
    localparam int REG_ONE_BIT      = 1;
    localparam logic [7:0] MASK_WR_BITS   = 8'hFE;
    localparam logic [7:0] ENABLE_WR_BITS = 8'h3E;
    localparam int SYNC_STAGES      = 2;
endpackage : ssr_pkg

// *** src/ssr_regs.sv ***
// Purpose : supply status, fault mask and supply enable register bank
// Assumes : byte register port decoded by a serial engine on the same clock
// Notes   : resetn_i stands for undervoltage lockout
// What this block does
// - status bits 7,6 show power-fail, low-battery below threshold
// - supply status bit high while output below target
// - disabled supply reports status zero
// - core rail status zero during voltage transition
// - status register read-only at 01h, bits 7..1
// - mask bit one blocks status from interrupt
// - mask register at 02h, resets to C0h
// - interrupt shows any unmasked status bit not blocked by a read
// - status bits active at read blocked from interrupt
// - supply on is enable bit AND pin
// - enable register at 03h, resets to FFh
// - low enable pin forces enable bit to one
// - host writes enable bits 5..1 while their pin is high
// - shared regulator pin restores regulator two bit
// - revision register read-only at 00h
// - address 1001000, unmapped reads return FFh
`timescale 1ns/1ps
module ssr_regs
    import ssr_pkg::*;
#(
    parameter logic [7:0] REVISION_ID = ssr_pkg::REVISION_ID_DEF  // arbitrary value
) (
    input  wire logic       clk_sys_i,
    input  wire logic       resetn_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic       rail_one_enable_pin_i,
    input  wire logic       rail_two_enable_pin_i,
    input  wire logic       rail_three_enable_pin_i,
    input  wire logic       linear_regulators_enable_pin_i,
    input  wire logic       power_fail_sense_low_i,
    input  wire logic       battery_sense_low_i,
    input  wire logic [4:0] supply_below_target_i,
    input  wire logic       dynamic_voltage_transition_i,
    output logic      [4:0] supply_on_o,
    output logic            interrupt_n_o
);
    import ssr_pkg::*;

    // ----------------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------------
    logic [10:0] pins_async;
    logic [10:0] pins_sync;
    logic        rail1_pin;
    logic        rail2_pin;
    logic        rail3_pin;
    logic        ldo_pin;
    logic        pf_low;
    logic        lb_low;
    logic [4:0]  below;

    assign pins_async = {rail_one_enable_pin_i, rail_two_enable_pin_i,
                         rail_three_enable_pin_i, linear_regulators_enable_pin_i,
                         power_fail_sense_low_i, battery_sense_low_i,
                         supply_below_target_i};

    ssr_sync #(
        .WIDTH (11)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .async_i   (pins_async),
        .sync_o    (pins_sync)
    );

    assign {rail1_pin, rail2_pin, rail3_pin, ldo_pin, pf_low, lb_low, below} = pins_sync;

    // ----------------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------------
    logic [7:0] fault_interrupt_mask;
    logic [7:0] supply_enable_ctrl;
    logic [7:0] supply_health_flags;
    logic [7:0] blocked;
    logic [7:0] pin8;
    logic [7:0] below8;
    logic [7:0] on8;
    logic [7:0] next_status;
    logic       wr_mask;
    logic       wr_enable;
    logic       rd_status;

    assign wr_mask   = reg_wr_i && (reg_addr_i == FAULT_MASK_OFS);
    assign wr_enable = reg_wr_i && (reg_addr_i == SUPPLY_ENABLE_OFS);
    assign rd_status = reg_rd_i && (reg_addr_i == SUPPLY_HEALTH_OFS);

    // regulator one and two share one enable pin
    assign pin8   = {2'b11, rail1_pin, rail2_pin, rail3_pin, ldo_pin, ldo_pin, 1'b1};
    assign below8 = {2'b00, below, 1'b0};
    assign on8    = supply_enable_ctrl & pin8;
    assign supply_on_o = on8[RAIL_ONE_BIT:REG_ONE_BIT];

    // mask: bits 7..1 writable, bit 0 stays zero
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            fault_interrupt_mask <= FAULT_MASK_RST;
        end else if (wr_mask) begin
            fault_interrupt_mask <= reg_wdata_i & MASK_WR_BITS;
        end
    end

    // enable: per bit, a low pin wins over a host write; one process owns the whole byte
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            supply_enable_ctrl <= SUPPLY_ENABLE_RST;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (!ENABLE_WR_BITS[i]) begin
                    supply_enable_ctrl[i] <= SUPPLY_ENABLE_RST[i];
                end else if (!pin8[i]) begin
                    supply_enable_ctrl[i] <= 1'b1;
                end else if (wr_enable) begin
                    supply_enable_ctrl[i] <= reg_wdata_i[i];
                end
            end
        end
    end

    // ----------------------------------------------------------------------
    // status and interrupt
    // ----------------------------------------------------------------------
    always_comb begin
        next_status                  = below8 & on8;
        next_status[POWER_FAIL_BIT]  = pf_low;
        next_status[LOW_BATTERY_BIT] = lb_low;
        if (dynamic_voltage_transition_i) begin
            next_status[RAIL_THREE_BIT] = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            supply_health_flags <= 8'h00;
        end else begin
            supply_health_flags <= next_status;
        end
    end

    // a bit stays blocked after a status read until it goes inactive
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            blocked <= 8'h00;
        end else if (rd_status) begin
            blocked <= supply_health_flags & next_status;
        end else begin
            blocked <= blocked & next_status;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            interrupt_n_o <= 1'b1;
        end else begin
            interrupt_n_o <= ~|(supply_health_flags & ~fault_interrupt_mask & ~blocked);
        end
    end

    // ----------------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                REVISION_ID_OFS:   reg_rdata_o <= REVISION_ID;
                SUPPLY_HEALTH_OFS: reg_rdata_o <= supply_health_flags;
                FAULT_MASK_OFS:    reg_rdata_o <= fault_interrupt_mask;
                SUPPLY_ENABLE_OFS: reg_rdata_o <= supply_enable_ctrl;
                default:           reg_rdata_o <= UNMAPPED_READ_VAL;
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------------
    property p_fail_flags;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        $past(resetn_i) |-> supply_health_flags[7:6] == $past({pf_low, lb_low});
    endproperty
    a_fail_flags: assert property (p_fail_flags) else $error("fail flags wrong");

    property p_off_no_fault;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        $past(resetn_i) && !$past(on8[RAIL_ONE_BIT]) |-> !supply_health_flags[RAIL_ONE_BIT];
    endproperty
    a_off_no_fault: assert property (p_off_no_fault) else $error("off rail flagged");

    property p_below_flag;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        on8[RAIL_TWO_BIT] && below8[RAIL_TWO_BIT] |=> supply_health_flags[RAIL_TWO_BIT];
    endproperty
    a_below_flag: assert property (p_below_flag) else $error("low rail not flagged");

    property p_dvt_zero;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        dynamic_voltage_transition_i |=> !supply_health_flags[RAIL_THREE_BIT];
    endproperty
    a_dvt_zero: assert property (p_dvt_zero) else $error("core flag in transition");

    property p_mask_all;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        fault_interrupt_mask == MASK_WR_BITS |=> interrupt_n_o;
    endproperty
    a_mask_all: assert property (p_mask_all) else $error("masked interrupt seen");

    property p_mask_reset;
        @(posedge clk_sys_i)
        $rose(resetn_i) |-> fault_interrupt_mask == FAULT_MASK_RST && supply_enable_ctrl == SUPPLY_ENABLE_RST;
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("bad reset values");

    property p_on_and;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        supply_on_o[0] == (supply_enable_ctrl[REG_ONE_BIT] && ldo_pin);
    endproperty
    a_on_and: assert property (p_on_and) else $error("supply on not AND");

    property p_pin_restore;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        !ldo_pin |=> supply_enable_ctrl[REG_TWO_BIT] && supply_enable_ctrl[REG_ONE_BIT];
    endproperty
    a_pin_restore: assert property (p_pin_restore) else $error("enable not restored");

    property p_ro_write;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        reg_wr_i && reg_addr_i == SUPPLY_HEALTH_OFS |=> $stable(fault_interrupt_mask);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only write stored");

    property p_unmapped;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        reg_rd_i && reg_addr_i > SUPPLY_ENABLE_OFS |=> reg_rdata_o == UNMAPPED_READ_VAL;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not FF");

    property p_block;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        rd_status ##1 $stable(supply_health_flags) |=> interrupt_n_o || |(supply_health_flags & ~$past(supply_health_flags, 2));
    endproperty
    a_block: assert property (p_block) else $error("read bits still interrupt");
endmodule : ssr_regs

// *** src/ssr_sync.sv ***
// Purpose : two flip-flop synchroniser for a group of pin levels
// Assumes : inputs are levels from outside the clock domain
// Notes   : first stage feeds only the second stage
`timescale 1ns/1ps
module ssr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys_i,
    input  wire logic             resetn_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule : ssr_sync

// *** test/ssr_host_model.sv ***
// Purpose : host side of the byte register port
// Assumes : one request at a time, tasks called from the bench
// Notes   : released address and data show the inverse of the last value
`timescale 1ns/1ps
module ssr_host_model (
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] reg_rdata_i,
    output logic      [7:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_rd_o
);
    initial begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o    = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        reg_wr_o    <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_o    <= 1'b0;
        reg_addr_o  <= ~a;
        reg_wdata_o <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_o <= a;
        reg_rd_o   <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_o   <= 1'b0;
        reg_addr_o <= ~a;
        #1 d = reg_rdata_i;
    endtask : rd
endmodule : ssr_host_model

// *** test/ssr_regs_tb.sv ***
// Purpose : self-checking bench for the supply register bank
// Assumes : host model drives the register port
// Notes   : pin changes settle within six clocks
`timescale 1ns/1ps
module ssr_regs_tb;
    import ssr_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        resetn_i  = 1'b0;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv, en_m, mask_m, blk, st;
    logic        reg_wr, reg_rd, int_n;
    logic [3:0]  pins = 4'hF;
    logic [4:0]  below = 5'h00;
    logic [4:0]  on;
    logic        pf = 1'b0, lb = 1'b0, dvt = 1'b0;
    logic [15:0] r = 16'h0001;
    int          errors = 0, checked = 0;
    // ----------------------------------------------------------------------
    // design and host
    // ----------------------------------------------------------------------
    always #12.5 clk_sys_i = ~clk_sys_i;
    ssr_host_model host (.clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr),
        .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd));
    ssr_regs dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr),
        .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .rail_one_enable_pin_i(pins[3]), .rail_two_enable_pin_i(pins[2]),
        .rail_three_enable_pin_i(pins[1]), .linear_regulators_enable_pin_i(pins[0]),
        .power_fail_sense_low_i(pf), .battery_sense_low_i(lb), .supply_below_target_i(below),
        .dynamic_voltage_transition_i(dvt), .supply_on_o(on), .interrupt_n_o(int_n));
    // ----------------------------------------------------------------------
    // expectations and helpers
    // ----------------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [7:0] pb();
        return {2'b00, pins[3], pins[2], pins[1], pins[0], pins[0], 1'b0};
    endfunction : pb
    function automatic logic [4:0] on_exp();
        return en_m[5:1] & {pins[3], pins[2], pins[1], pins[0], pins[0]};
    endfunction : on_exp
    function automatic logic [7:0] exp_st();
        logic [7:0] s;
        s = {pf, lb, below & on_exp(), 1'b0};
        if (dvt) s[3] = 1'b0;
        return s;
    endfunction : exp_st
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic settle();
        repeat (6) @(posedge clk_sys_i);
        en_m = en_m | (~pb() & ENABLE_WR_BITS);
    endtask : settle
    task automatic wr_en(input logic [7:0] d);
        host.wr(SUPPLY_ENABLE_OFS, d);
        en_m = (en_m & ~(ENABLE_WR_BITS & pb())) | (d & ENABLE_WR_BITS & pb());
    endtask : wr_en
    task automatic reset();
        @(posedge clk_sys_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        en_m   = SUPPLY_ENABLE_RST;
        mask_m = FAULT_MASK_RST;
        blk    = 8'h00;
    endtask : reset
    task automatic wrap_up();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        errors++;
        wrap_up();
    end
    initial begin
        reset();
        host.rd(REVISION_ID_OFS, rv); chk(rv, REVISION_ID_DEF);
        host.rd(FAULT_MASK_OFS, rv); chk(rv, FAULT_MASK_RST);
        host.rd(SUPPLY_ENABLE_OFS, rv); chk(rv, SUPPLY_ENABLE_RST);
        host.rd(8'h04, rv); chk(rv, UNMAPPED_READ_VAL);
        host.wr(REVISION_ID_OFS, 8'h00);
        host.wr(SUPPLY_HEALTH_OFS, 8'hFF);
        host.rd(REVISION_ID_OFS, rv); chk(rv, REVISION_ID_DEF);
        repeat (40) begin
            r = lfsr(r);
            @(posedge clk_sys_i);
            pins  <= r[3:0];
            below <= r[8:4];
            pf    <= r[9];
            lb    <= r[10];
            dvt   <= r[11];
            settle();
            blk = blk & exp_st();
            host.wr(FAULT_MASK_OFS, r[15:8]);
            mask_m = r[15:8] & MASK_WR_BITS;
            wr_en(r[7:0] ^ r[15:8]);
            settle();
            st  = exp_st();
            blk = blk & st;
            chk({3'b000, on}, {3'b000, on_exp()});
            chk({7'h00, int_n}, {7'h00, ~|(st & ~mask_m & ~blk)});
            host.rd(SUPPLY_HEALTH_OFS, rv); chk(rv, st);
            blk = blk | st;
            host.rd(FAULT_MASK_OFS, rv); chk(rv, mask_m);
            host.rd(SUPPLY_ENABLE_OFS, rv); chk(rv, en_m);
            settle();
            chk({7'h00, int_n}, 8'h01);
        end
        reset();
        host.rd(FAULT_MASK_OFS, rv); chk(rv, FAULT_MASK_RST);
        wrap_up();
    end
endmodule : ssr_regs_tb
